// [pkg/ocb_consts.svh]
// constants for the overcurrent block/event logic
`ifndef OCB_CONSTS_SVH
`define OCB_CONSTS_SVH
`define OCB_CLK_KHZ      10000
`define OCB_CYCLE_US     5000
`define OCB_NSTAGE       4
`define OCB_NEVT         18
`define OCB_NSIG         9
`define OCB_HIST         12
`define OCB_PRE1_CYC     4
`define OCB_PRE2_CYC     40
`define OCB_RELEASE_PCT  97
`define OCB_PCT_FULL     100
`define OCB_A_CTRL       8'h00
`define OCB_A_FORCE      8'h04
`define OCB_A_HSEL       8'h08
`define OCB_A_HD0        8'h0c
`define OCB_A_HD1        8'h10
`define OCB_A_HD2        8'h14
`define OCB_A_HD3        8'h18
`define OCB_A_STG        8'h20
`define OCB_A_STG_END    8'h60
`define OCB_O_THR        2'h0
`define OCB_O_DLY        2'h1
`define OCB_O_INR        2'h2
`define OCB_O_STAT       2'h3
`define OCB_F_IDMT       16
`define OCB_F_INR_EN     16
`define OCB_F_FORCE_EN   2
`define OCB_R_MODE       2'h3
`define OCB_R_THR        16'h0078
`define OCB_R_DLY        16'h0014
`define OCB_R_INR_LIM    16'h0001
`endif

// [pkg/ocb_pkg.sv]
// shared types and helpers for the overcurrent block/event logic
`include "ocb_consts.svh"
package ocb_pkg;
	typedef enum logic [1:0] {
		OCB_IDLE    = 2'b00,
		OCB_START   = 2'b01,
		OCB_TRIP    = 2'b11,
		OCB_BLOCKED = 2'b10
	} ocb_state_t;

	function automatic logic [15:0] ocb_max3(input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] c);
		logic [15:0] m;
		m = (a > b) ? a : b;
		return (m > c) ? m : c;
	endfunction

	// ring index stepped back by some program cycles
	function automatic logic [5:0] ocb_ring_back(input logic [5:0] p, input logic [5:0] back);
		logic [6:0] s;
		s = 7'(p) + 7'(`OCB_PRE2_CYC) - 7'(back);
		return (s >= 7'(`OCB_PRE2_CYC)) ? 6'(s - 7'(`OCB_PRE2_CYC)) : 6'(s);
	endfunction
endpackage

// [hdl/ocb_stage.sv]
// one overcurrent stage: pick-up, block gating, start/trip timing
`timescale 1ns/10ps
`include "ocb_consts.svh"
module ocb_stage import ocb_pkg::*; (
	// clock, reset, program tick
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        tick_i,
	// measurements
	input  wire logic [15:0] meas_a_i,
	input  wire logic [15:0] meas_b_i,
	input  wire logic [15:0] meas_c_i,
	input  wire logic [15:0] harm_ratio_i,
	// settings
	input  wire logic [15:0] thr_i,
	input  wire logic [15:0] dly_i,
	input  wire logic        idmt_i,
	input  wire logic        inr_en_i,
	input  wire logic [15:0] inr_lim_i,
	input  wire logic        block_i,
	// status
	output logic             start_o,
	output logic             trip_o,
	output logic             blocked_o,
	output logic [2:0]       ph_start_o,
	output logic [2:0]       ph_trip_o,
	output logic [2:0]       pick_o,
	output logic [15:0]      remain_o
);
	ocb_state_t  state;
	ocb_state_t  next_state;
	logic [15:0] timer;
	logic [15:0] next_timer;
	logic [15:0] rel_lvl;
	logic [2:0]  next_pick;
	logic        blk_now;
	logic [15:0] step;
	logic [15:0] mx;

	function automatic logic held(input logic [15:0] m, input logic [15:0] thr,
		input logic [15:0] rel, input logic prev);
		return prev ? (m >= rel) : (m > thr);
	endfunction

	assign rel_lvl = 16'((32'(thr_i) * `OCB_RELEASE_PCT) / `OCB_PCT_FULL);
	assign mx      = ocb_max3(meas_a_i, meas_b_i, meas_c_i);

	always_comb begin
		next_pick[0] = held(meas_a_i, thr_i, rel_lvl, pick_o[0]);
		next_pick[1] = held(meas_b_i, thr_i, rel_lvl, pick_o[1]);
		next_pick[2] = held(meas_c_i, thr_i, rel_lvl, pick_o[2]);
		blk_now = block_i | (inr_en_i & (harm_ratio_i > inr_lim_i));
		if (idmt_i && thr_i != 16'h0000 && mx / thr_i > 16'h0001) begin
			step = mx / thr_i;
		end else begin
			step = 16'h0001;
		end
		next_state = state;
		next_timer = timer;
		unique case (state)
			OCB_IDLE: begin
				if (|next_pick && blk_now) begin
					next_state = OCB_BLOCKED;
				end else if (|next_pick) begin
					next_state = OCB_START;
					next_timer = dly_i;
				end
			end
			OCB_START: begin
				if (!(|next_pick) || blk_now) begin
					next_state = OCB_IDLE;
					next_timer = 16'h0000;
				end else if (timer <= step) begin
					next_state = OCB_TRIP;
					next_timer = 16'h0000;
				end else begin
					next_timer = timer - step;
				end
			end
			OCB_TRIP: begin
				if (!(|next_pick) || blk_now) begin
					next_state = OCB_IDLE;
				end
			end
			OCB_BLOCKED: begin
				if (!(|next_pick)) begin
					next_state = OCB_IDLE;
				end
			end
		endcase
	end

	// everything below moves only on the program tick
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state  <= OCB_IDLE;
			timer  <= 16'h0000;
			pick_o <= 3'h0;
		end else if (tick_i) begin
			state  <= next_state;
			timer  <= next_timer;
			pick_o <= next_pick;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			start_o    <= 1'b0;
			trip_o     <= 1'b0;
			blocked_o  <= 1'b0;
			ph_start_o <= 3'h0;
			ph_trip_o  <= 3'h0;
			remain_o   <= 16'h0000;
		end else if (tick_i) begin
			start_o    <= next_state == OCB_START || next_state == OCB_TRIP;
			trip_o     <= next_state == OCB_TRIP;
			blocked_o  <= next_state == OCB_BLOCKED;
			ph_start_o <= (next_state == OCB_START || next_state == OCB_TRIP) ? next_pick : 3'h0;
			ph_trip_o  <= (next_state == OCB_TRIP) ? next_pick : 3'h0;
			remain_o   <= (next_state == OCB_START) ? next_timer : 16'h0000;
		end
	end
endmodule

// [hdl/ocb_top.sv]
// four overcurrent stages with registers, event stream and fault history
//
// Functional notes
// - block input sampled once per program cycle
// - internal second-harmonic inrush block source
// - pick-up without block gives start, timing
// - pick-up while blocked gives blocked only
// - block after start drops start, releases
// - block raises notification and block event
// - inrush enable bit, default disabled
// - inrush limit in 0.01 percent steps
// - forcing mode lets software switch block
// - definite-time and inverse-time operate delays
// - events on every edge, per phase too
// - select on, off or both events
// - four stages, events tagged per stage
// - events carry time stamp and highest phase current
// - twelve-record history per stage, oldest overwritten
// - record written on start, trip, block assert
// - record holds time, currents, remaining, group
// - pick-up when any phase exceeds threshold
// - release below 97 percent of threshold
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "ocb_consts.svh"
module ocb_top import ocb_pkg::*; #(
	parameter int CYCLE_CLKS = `OCB_CYCLE_US * `OCB_CLK_KHZ / 1000
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// avalon-mm slave
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	// measurements and context
	input  wire logic [15:0] meas_a_i,
	input  wire logic [15:0] meas_b_i,
	input  wire logic [15:0] meas_c_i,
	input  wire logic [15:0] harm_ratio_i,
	input  wire logic [3:0]  ext_block_i,
	input  wire logic [31:0] time_i,
	input  wire logic [2:0]  setting_group_i,
	// event stream
	output logic             evt_valid_o,
	input  wire logic        evt_ready_i,
	output logic [1:0]       evt_stage_o,
	output logic [4:0]       evt_code_o,
	output logic [31:0]      evt_time_o,
	output logic [15:0]      evt_current_o,
	output logic [2:0]       evt_fault_o,
	// stage status
	output logic [3:0]       start_o,
	output logic [3:0]       trip_o,
	output logic [3:0]       blocked_o,
	output logic             hmi_block_o
);
	localparam int NP = `OCB_NSTAGE * `OCB_NEVT;

	// ********************************
	// program tick
	// ********************************
	logic [31:0] div_cnt;
	logic        tick;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt <= 32'h0;
			tick    <= 1'b0;
		end else begin
			tick    <= div_cnt == 32'(CYCLE_CLKS - 1);
			div_cnt <= (div_cnt == 32'(CYCLE_CLKS - 1)) ? 32'h0 : div_cnt + 32'h1;
		end
	end

	// ********************************
	// registers and bus slave
	// ********************************
	logic [1:0]  evt_mode;
	logic        force_en;
	logic [3:0]  force_blk;
	logic [1:0]  hsel_stage;
	logic [3:0]  hsel_slot;
	logic [15:0] thr     [`OCB_NSTAGE];
	logic [15:0] dly     [`OCB_NSTAGE];
	logic        idmt    [`OCB_NSTAGE];
	logic [15:0] inr_lim [`OCB_NSTAGE];
	logic        inr_en  [`OCB_NSTAGE];
	logic [31:0] next_rdata;
	logic        req;
	logic [7:0]  soff;
	logic [1:0]  sidx;
	logic        in_stg;

	assign req    = avs_read_i | avs_write_i;
	assign in_stg = avs_address_i >= `OCB_A_STG && avs_address_i < `OCB_A_STG_END;
	assign soff   = avs_address_i - `OCB_A_STG;
	assign sidx   = soff[5:4];

	// answer one cycle after the request is seen
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h0;
		end else begin
			avs_waitrequest_o <= !(req && avs_waitrequest_o);
			if (avs_read_i && avs_waitrequest_o) begin
				avs_readdata_o <= next_rdata;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			evt_mode   <= `OCB_R_MODE;
			force_en   <= 1'b0;
			force_blk  <= 4'h0;
			hsel_stage <= 2'h0;
			hsel_slot  <= 4'h0;
			for (int s = 0; s < `OCB_NSTAGE; s++) begin
				thr[s]     <= `OCB_R_THR;
				dly[s]     <= `OCB_R_DLY;
				idmt[s]    <= 1'b0;
				inr_lim[s] <= `OCB_R_INR_LIM;
				inr_en[s]  <= 1'b0;
			end
		end else if (avs_write_i && !avs_waitrequest_o) begin
			if (avs_address_i == `OCB_A_CTRL) begin
				evt_mode <= avs_writedata_i[1:0];
				force_en <= avs_writedata_i[`OCB_F_FORCE_EN];
			end
			if (avs_address_i == `OCB_A_FORCE) begin
				force_blk <= avs_writedata_i[3:0];
			end
			if (avs_address_i == `OCB_A_HSEL) begin
				hsel_stage <= avs_writedata_i[1:0];
				hsel_slot  <= avs_writedata_i[11:8];
			end
			if (in_stg && soff[3:2] == `OCB_O_THR) begin
				thr[sidx] <= avs_writedata_i[15:0];
			end
			if (in_stg && soff[3:2] == `OCB_O_DLY) begin
				dly[sidx]  <= avs_writedata_i[15:0];
				idmt[sidx] <= avs_writedata_i[`OCB_F_IDMT];
			end
			if (in_stg && soff[3:2] == `OCB_O_INR) begin
				inr_lim[sidx] <= avs_writedata_i[15:0];
				inr_en[sidx]  <= avs_writedata_i[`OCB_F_INR_EN];
			end
		end
	end

	// ********************************
	// stages
	// ********************************
	logic [2:0]  ph_start [`OCB_NSTAGE];
	logic [2:0]  ph_trip  [`OCB_NSTAGE];
	logic [2:0]  pick     [`OCB_NSTAGE];
	logic [15:0] remain   [`OCB_NSTAGE];
	logic [8:0]  sig      [`OCB_NSTAGE];
	logic [8:0]  sig_prev [`OCB_NSTAGE];

	for (genvar g = 0; g < `OCB_NSTAGE; g++) begin : g_stage
		ocb_stage u_stage (
			.clk_i        (clk_i),
			.rst_i        (rst_i),
			.tick_i       (tick),
			.meas_a_i     (meas_a_i),
			.meas_b_i     (meas_b_i),
			.meas_c_i     (meas_c_i),
			.harm_ratio_i (harm_ratio_i),
			.thr_i        (thr[g]),
			.dly_i        (dly[g]),
			.idmt_i       (idmt[g]),
			.inr_en_i     (inr_en[g]),
			.inr_lim_i    (inr_lim[g]),
			.block_i      (ext_block_i[g] | (force_en & force_blk[g])),
			.start_o      (start_o[g]),
			.trip_o       (trip_o[g]),
			.blocked_o    (blocked_o[g]),
			.ph_start_o   (ph_start[g]),
			.ph_trip_o    (ph_trip[g]),
			.pick_o       (pick[g]),
			.remain_o     (remain[g])
		);
		assign sig[g] = {ph_trip[g], ph_start[g], blocked_o[g], trip_o[g], start_o[g]};
	end

	// ********************************
	// pre-fault current ring
	// ********************************
	logic [15:0] ring [`OCB_PRE2_CYC];
	logic [5:0]  rptr;
	logic [15:0] cur_now;

	assign cur_now = ocb_max3(meas_a_i, meas_b_i, meas_c_i);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rptr <= 6'h0;
			for (int i = 0; i < `OCB_PRE2_CYC; i++) begin
				ring[i] <= 16'h0;
			end
		end else if (tick) begin
			ring[rptr] <= cur_now;
			rptr       <= ocb_ring_back(rptr, 6'(`OCB_PRE2_CYC - 1));
		end
	end

	// ********************************
	// event pending set and emitter
	// ********************************
	logic [NP-1:0] pend;
	logic [NP-1:0] set_v;
	logic [NP-1:0] clr_v;
	logic [6:0]    first;
	logic          found;

	always_comb begin
		set_v = '0;
		for (int s = 0; s < `OCB_NSTAGE; s++) begin
			for (int b = 0; b < `OCB_NSIG; b++) begin
				set_v[s*`OCB_NEVT + 2*b]     = sig[s][b] & ~sig_prev[s][b] & evt_mode[0];
				set_v[s*`OCB_NEVT + 2*b + 1] = ~sig[s][b] & sig_prev[s][b] & evt_mode[1];
			end
		end
		found = 1'b0;
		first = 7'h0;
		for (int i = NP - 1; i >= 0; i--) begin
			if (pend[i]) begin
				found = 1'b1;
				first = 7'(i);
			end
		end
	end

	assign clr_v = (found && (!evt_valid_o || evt_ready_i)) ? (NP'(1) << first) : '0;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pend <= '0;
			for (int s = 0; s < `OCB_NSTAGE; s++) begin
				sig_prev[s] <= 9'h0;
			end
		end else begin
			pend <= (pend & ~clr_v) | set_v;
			for (int s = 0; s < `OCB_NSTAGE; s++) begin
				sig_prev[s] <= sig[s];
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			evt_valid_o   <= 1'b0;
			evt_stage_o   <= 2'h0;
			evt_code_o    <= 5'h0;
			evt_time_o    <= 32'h0;
			evt_current_o <= 16'h0;
			evt_fault_o   <= 3'h0;
		end else if (!evt_valid_o || evt_ready_i) begin
			evt_valid_o <= found;
			if (found) begin
				evt_stage_o   <= 2'(first / 7'(`OCB_NEVT));
				evt_code_o    <= 5'(first % 7'(`OCB_NEVT));
				evt_time_o    <= time_i;
				evt_current_o <= cur_now;
				evt_fault_o   <= pick[2'(first / 7'(`OCB_NEVT))];
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hmi_block_o <= 1'b0;
		end else begin
			hmi_block_o <= |(blocked_o & ~{sig_prev[3][2], sig_prev[2][2],
				sig_prev[1][2], sig_prev[0][2]});
		end
	end

	// ********************************
	// fault history
	// ********************************
	logic [31:0] h_time  [`OCB_NSTAGE][`OCB_HIST];
	logic [4:0]  h_code  [`OCB_NSTAGE][`OCB_HIST];
	logic [2:0]  h_fault [`OCB_NSTAGE][`OCB_HIST];
	logic [2:0]  h_sg    [`OCB_NSTAGE][`OCB_HIST];
	logic [15:0] h_pre1  [`OCB_NSTAGE][`OCB_HIST];
	logic [15:0] h_cur   [`OCB_NSTAGE][`OCB_HIST];
	logic [15:0] h_pre2  [`OCB_NSTAGE][`OCB_HIST];
	logic [15:0] h_rem   [`OCB_NSTAGE][`OCB_HIST];
	logic [3:0]  wp      [`OCB_NSTAGE];
	logic [2:0]  rise    [`OCB_NSTAGE];
	logic [4:0]  code    [`OCB_NSTAGE];

	// one record per stage and clock: trip before start before blocked
	always_comb begin
		for (int s = 0; s < `OCB_NSTAGE; s++) begin
			rise[s] = sig[s][2:0] & ~sig_prev[s][2:0];
			code[s] = rise[s][1] ? 5'h2 : (rise[s][0] ? 5'h0 : 5'h4);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int s = 0; s < `OCB_NSTAGE; s++) begin
				wp[s] <= 4'h0;
			end
		end else begin
			for (int s = 0; s < `OCB_NSTAGE; s++) begin
				if (|rise[s]) begin
					h_time[s][wp[s]]  <= time_i;
					h_code[s][wp[s]]  <= code[s];
					h_fault[s][wp[s]] <= pick[s];
					h_sg[s][wp[s]]    <= setting_group_i;
					h_pre1[s][wp[s]]  <= ring[ocb_ring_back(rptr, 6'(`OCB_PRE1_CYC))];
					h_cur[s][wp[s]]   <= cur_now;
					h_pre2[s][wp[s]]  <= ring[rptr];
					h_rem[s][wp[s]]   <= remain[s];
					wp[s] <= (wp[s] == 4'(`OCB_HIST - 1)) ? 4'h0 : wp[s] + 4'h1;
				end
			end
		end
	end

	// ********************************
	// read mux
	// ********************************
	always_comb begin
		next_rdata = 32'h0;
		unique case (avs_address_i)
			`OCB_A_CTRL:  next_rdata = {29'h0, force_en, evt_mode};
			`OCB_A_FORCE: next_rdata = {28'h0, force_blk};
			`OCB_A_HSEL:  next_rdata = {12'h0, wp[hsel_stage], 4'h0, hsel_slot, 6'h0, hsel_stage};
			`OCB_A_HD0:   next_rdata = h_time[hsel_stage][hsel_slot];
			`OCB_A_HD1:   next_rdata = {3'h0, h_code[hsel_stage][hsel_slot], 5'h0,
				h_fault[hsel_stage][hsel_slot], 13'h0, h_sg[hsel_stage][hsel_slot]};
			`OCB_A_HD2:   next_rdata = {h_pre1[hsel_stage][hsel_slot], h_cur[hsel_stage][hsel_slot]};
			`OCB_A_HD3:   next_rdata = {h_pre2[hsel_stage][hsel_slot], h_rem[hsel_stage][hsel_slot]};
			default: begin
				if (in_stg) begin
					unique case (soff[3:2])
						`OCB_O_THR:  next_rdata = {16'h0, thr[sidx]};
						`OCB_O_DLY:  next_rdata = {15'h0, idmt[sidx], dly[sidx]};
						`OCB_O_INR:  next_rdata = {15'h0, inr_en[sidx], inr_lim[sidx]};
						`OCB_O_STAT: next_rdata = {sig[sidx], 7'h0, remain[sidx]};
					endcase
				end
			end
		endcase
	end
endmodule

// [sim/ocb_chk_assertions.sv]
// concurrent checks on the ports of the overcurrent block and event top
`timescale 1ns/10ps
module ocb_chk (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// register bus
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_readdata_o,
	input  wire logic        avs_waitrequest_o,
	// events and status
	input  wire logic        evt_valid_o,
	input  wire logic        evt_ready_i,
	input  wire logic [1:0]  evt_stage_o,
	input  wire logic [4:0]  evt_code_o,
	input  wire logic [31:0] evt_time_o,
	input  wire logic [31:0] time_i,
	input  wire logic [3:0]  start_o,
	input  wire logic [3:0]  trip_o,
	input  wire logic [3:0]  blocked_o,
	input  wire logic        hmi_block_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ****************************************
	// bus handshake
	// ****************************************
	sequence s_req;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_ans;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	property p_bus_answer;
		s_req |=> s_ans;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("bus answer not one cycle after request");
	property p_bus_quiet;
		!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i);
	endproperty
	a_bus_quiet: assert property (p_bus_quiet)
		else $error("bus answer without request");
	property p_rdata;
		$changed(avs_readdata_o) |-> !avs_waitrequest_o && avs_read_i;
	endproperty
	a_rdata: assert property (p_rdata)
		else $error("read data moved outside a read answer");
	// ****************************************
	// events and stage status
	// ****************************************
	property p_evt_hold;
		evt_valid_o && !evt_ready_i |=> evt_valid_o && $stable(evt_code_o) && $stable(evt_stage_o);
	endproperty
	a_evt_hold: assert property (p_evt_hold)
		else $error("event dropped before taken");
	property p_evt_code;
		evt_valid_o |-> evt_code_o < 5'd18;
	endproperty
	a_evt_code: assert property (p_evt_code)
		else $error("event code out of range");
	sequence s_load;
		evt_valid_o && (!$past(evt_valid_o) || $past(evt_ready_i));
	endsequence
	property p_evt_stamp;
		s_load |-> evt_time_o == $past(time_i);
	endproperty
	a_evt_stamp: assert property (p_evt_stamp)
		else $error("event time stamp not taken at emission");
	property p_excl;
		(start_o & blocked_o) == 4'h0;
	endproperty
	a_excl: assert property (p_excl)
		else $error("start and blocked together");
	property p_start_src;
		(start_o & ~$past(start_o) & $past(blocked_o)) == 4'h0;
	endproperty
	a_start_src: assert property (p_start_src)
		else $error("start rose from blocked");
	property p_trip_src;
		(trip_o & ~$past(trip_o) & ~$past(start_o)) == 4'h0;
	endproperty
	a_trip_src: assert property (p_trip_src)
		else $error("trip rose without start");
	property p_hmi_pulse;
		hmi_block_o |=> !hmi_block_o;
	endproperty
	a_hmi_pulse: assert property (p_hmi_pulse)
		else $error("notification longer than one cycle");
	property p_hmi_cause;
		(blocked_o & ~$past(blocked_o)) != 4'h0 |-> (##[0:2] hmi_block_o) or $past(hmi_block_o);
	endproperty
	a_hmi_cause: assert property (p_hmi_cause)
		else $error("block without notification");
endmodule
bind ocb_top ocb_chk i_ocb_chk (.clk_i, .rst_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
	.avs_waitrequest_o, .evt_valid_o, .evt_ready_i, .evt_stage_o, .evt_code_o, .evt_time_o,
	.time_i, .start_o, .trip_o, .blocked_o, .hmi_block_o);

// [sim/ocb_partner.sv]
// block command register, time source and counting event sink around the top
`timescale 1ns/10ps
module ocb_partner (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// event stream
	input  wire logic        evt_valid_i,
	input  wire logic [1:0]  evt_stage_i,
	input  wire logic [4:0]  evt_code_i,
	output logic             evt_ready_o,
	// block commands and context
	input  wire logic [3:0]  block_cmd_i,
	input  wire logic        slow_i,
	output logic [3:0]       ext_block_o,
	output logic [31:0]      time_o
);
	int         cnt [4][18];
	logic [1:0] div;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ext_block_o <= 4'h0;
			time_o <= 32'h0;
			div <= 2'h0;
		end else begin
			ext_block_o <= block_cmd_i;
			time_o <= time_o + 32'h1;
			div <= div + 2'h1;
		end
	end
	// when slow, takes one event in four cycles
	assign evt_ready_o = !slow_i || div == 2'h3;
	always @(posedge clk_i) begin
		if (!rst_i && evt_valid_i && evt_ready_o && evt_code_i < 5'd18) begin
			cnt[evt_stage_i][evt_code_i] <= cnt[evt_stage_i][evt_code_i] + 1;
		end
	end
endmodule

// [sim/ocb_top_tb.sv]
// self-checking bench for the overcurrent block and event top
`timescale 1ns/10ps
`include "ocb_consts.svh"
module ocb_top_tb;
	localparam int TICK = 20;
	logic        clk_i;
	logic        rst_i;
	logic [7:0]  avs_address_i;
	logic        avs_read_i;
	logic        avs_write_i;
	logic [31:0] avs_writedata_i;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic [15:0] meas_a_i;
	logic [15:0] harm_ratio_i;
	logic [3:0]  ext_block_i;
	logic [31:0] time_i;
	logic        evt_valid_o;
	logic        evt_ready_i;
	logic [1:0]  evt_stage_o;
	logic [4:0]  evt_code_o;
	logic [15:0] evt_current_o;
	logic [2:0]  evt_fault_o;
	logic [3:0]  start_o;
	logic [3:0]  trip_o;
	logic [3:0]  blocked_o;
	logic        hmi_block_o;
	logic [3:0]  blk_cmd;
	logic        slow;
	logic [31:0] q;
	int          failures;
	int          n_checks;
	int          n;
	int          c0;
	int          c1;
	ocb_top #(.CYCLE_CLKS(TICK)) i_ocb_top (.clk_i, .rst_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .meas_a_i,
		.meas_b_i(16'h0), .meas_c_i(16'h0), .harm_ratio_i, .ext_block_i, .time_i,
		.setting_group_i(3'h5), .evt_valid_o, .evt_ready_i, .evt_stage_o, .evt_code_o,
		.evt_time_o(), .evt_current_o, .evt_fault_o, .start_o, .trip_o, .blocked_o,
		.hmi_block_o);
	ocb_partner i_ocb_partner (.clk_i, .rst_i, .evt_valid_i(evt_valid_o),
		.evt_stage_i(evt_stage_o), .evt_code_i(evt_code_o), .evt_ready_o(evt_ready_i),
		.block_cmd_i(blk_cmd), .slow_i(slow), .ext_block_o(ext_block_i), .time_o(time_i));
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_read_i <= ~wr;
		avs_write_i <= wr;
		do begin
			@(posedge clk_i);
		end while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(nm, q, exp);
	endtask
	function automatic logic [7:0] sa(input int s, input logic [1:0] o);
		return `OCB_A_STG + 8'(s * 16) + {4'h0, o, 2'b00};
	endfunction
	task automatic wait_st(input int k, input int s, input logic v);
		logic [3:0] w;
		n = 0;
		do begin
			@(negedge clk_i);
			w = (k == 0) ? start_o : (k == 1) ? trip_o : blocked_o;
			n++;
		end while (w[s] !== v && n < 400);
		if (n == 400) failures++;
	endtask
	task automatic mset(input logic [15:0] v);
		@(posedge clk_i);
		meas_a_i <= v;
	endtask
	task automatic pulse(input int s);
		mset(16'd150);
		wait_st(0, s, 1'b1);
		mset(16'd0);
		wait_st(0, s, 1'b0);
	endtask
	task automatic blk(input logic [3:0] v);
		@(posedge clk_i);
		blk_cmd <= v;
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ****************************************
	// clock, watchdog and tests
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		#2000000;
		failures++;
		give_verdict();
	end
	initial begin
		rst_i = 1'b1;
		{avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = '0;
		{meas_a_i, harm_ratio_i, blk_cmd, slow} = '0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk("ctrl", `OCB_A_CTRL, 32'h3);
		rdchk("threshold", sa(0, `OCB_O_THR), 32'h78);
		rdchk("delay", sa(0, `OCB_O_DLY), 32'h14);
		rdchk("inrush", sa(1, `OCB_O_INR), 32'h1);
		bus(1'b1, 8'h64, 32'h5a5a5a5a);
		rdchk("unmapped", 8'h64, 32'h0);
		bus(1'b1, sa(1, `OCB_O_INR), 32'h000104d2);
		rdchk("inrush limit", sa(1, `OCB_O_INR), 32'h000104d2);
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, sa(s, `OCB_O_THR), 32'hffff);
		end
		$display("test registers done");
		bus(1'b0, `OCB_A_HSEL, 32'h0);
		c0 = int'(q[19:16]);
		bus(1'b1, sa(0, `OCB_O_DLY), 32'h3);
		bus(1'b1, sa(0, `OCB_O_THR), 32'd100);
		mset(16'd150);
		wait_st(0, 0, 1'b1);
		wait_st(1, 0, 1'b1);
		chk("trip delay", n, 3 * TICK);
		mset(16'd0);
		wait_st(0, 0, 1'b0);
		chk("trip released", trip_o[0], 1'b0);
		bus(1'b0, `OCB_A_HSEL, 32'h0);
		chk("history pointer", q[19:16], 32'((c0 + 2) % 12));
		bus(1'b1, `OCB_A_HSEL, {20'h0, 4'(c0), 8'h0});
		bus(1'b0, `OCB_A_HD1, 32'h0);
		chk("record code", q[28:24], 32'h0);
		chk("record group", q[2:0], 32'h5);
		chk("record fault", q[18:16], 32'h1);
		chk("start event", i_ocb_partner.cnt[0][0], 1);
		chk("phase trip event", i_ocb_partner.cnt[0][12], 1);
		bus(1'b1, sa(0, `OCB_O_DLY), 32'h10006);
		mset(16'd300);
		wait_st(0, 0, 1'b1);
		wait_st(1, 0, 1'b1);
		chk("idmt delay", n, 2 * TICK);
		mset(16'd0);
		wait_st(0, 0, 1'b0);
		bus(1'b1, sa(0, `OCB_O_THR), 32'hffff);
		$display("test definite time done");
		bus(1'b1, sa(2, `OCB_O_DLY), 32'h100);
		bus(1'b1, sa(2, `OCB_O_THR), 32'd100);
		blk(4'h4);
		repeat (2 * TICK) @(posedge clk_i);
		mset(16'd150);
		wait_st(2, 2, 1'b1);
		repeat (2) @(negedge clk_i);
		chk("block evt", {evt_stage_o, evt_code_o, evt_fault_o}, {2'h2, 5'h4, 3'h1});
		chk("block current", {evt_valid_o, evt_current_o}, {1'b1, 16'h0096});
		chk("no start", start_o[2], 1'b0);
		mset(16'd0);
		wait_st(2, 2, 1'b0);
		chk("block event", i_ocb_partner.cnt[2][4], 1);
		blk(4'h0);
		mset(16'd150);
		wait_st(0, 2, 1'b1);
		c1 = i_ocb_partner.cnt[2][1];
		blk(4'h4);
		wait_st(2, 2, 1'b1);
		chk("start dropped", start_o[2], 1'b0);
		repeat (TICK) @(posedge clk_i);
		chk("start off event", i_ocb_partner.cnt[2][1] - c1, 1);
		mset(16'd0);
		wait_st(2, 2, 1'b0);
		blk(4'h0);
		bus(1'b1, sa(2, `OCB_O_THR), 32'hffff);
		$display("test external block done");
		bus(1'b1, `OCB_A_FORCE, 32'h8);
		bus(1'b1, sa(3, `OCB_O_THR), 32'd100);
		pulse(3);
		chk("force ignored", blocked_o[3], 1'b0);
		bus(1'b1, `OCB_A_CTRL, 32'h7);
		mset(16'd150);
		wait_st(2, 3, 1'b1);
		chk("forced block", start_o[3], 1'b0);
		mset(16'd0);
		wait_st(2, 3, 1'b0);
		bus(1'b1, `OCB_A_CTRL, 32'h3);
		bus(1'b1, sa(3, `OCB_O_THR), 32'hffff);
		$display("test forcing done");
		bus(1'b1, sa(1, `OCB_O_THR), 32'd100);
		@(posedge clk_i);
		harm_ratio_i <= 16'd1300;
		mset(16'd150);
		wait_st(2, 1, 1'b1);
		chk("inrush block", start_o[1], 1'b0);
		mset(16'd0);
		wait_st(2, 1, 1'b0);
		@(posedge clk_i);
		harm_ratio_i <= 16'd1000;
		pulse(1);
		chk("inrush clear", blocked_o[1], 1'b0);
		$display("test inrush done");
		@(posedge clk_i);
		slow <= 1'b1;
		for (int m = 1; m < 3; m++) begin
			bus(1'b1, `OCB_A_CTRL, 32'(m));
			c0 = i_ocb_partner.cnt[1][0];
			c1 = i_ocb_partner.cnt[1][1];
			pulse(1);
			repeat (TICK) @(posedge clk_i);
			chk("assert events", i_ocb_partner.cnt[1][0] - c0, m & 1);
			chk("deassert events", i_ocb_partner.cnt[1][1] - c1, m >> 1);
		end
		$display("test event filter done");
		give_verdict();
	end
endmodule
